// ---- core/lvm_defines.vh ----
// Constants for the legacy virtual mode transition unit
`ifndef LVM_DEFINES_VH
`define LVM_DEFINES_VH
// Flag bit positions in the flags register
`define LVM_LVF_BIT 17
`define LVM_NTF_BIT 14
`define LVM_IEF_BIT 9
`define LVM_SSF_BIT 8
// Gate and task segment descriptor types
`define LVM_TRAP_GATE32 4'hE
`define LVM_INTR_GATE32 4'hF
`define LVM_TSEG32_AVAIL 4'h9
`define LVM_TSEG32_BUSY 4'hB
// Privilege levels
`define LVM_PRIV_KERNEL 2'h0
`define LVM_PRIV_USER 2'h3
// Null selector and word step
`define LVM_NULL_SEL 16'h0000
`define LVM_WORD 32'h00000004
// Entry frame: nine words below the level-0 stack top
`define LVM_ENTRY_FRAME 32'h00000024
`define LVM_PUSH_LAST 4'h8
// Return frame offsets from stack pointer at return start
`define LVM_OFF_FLG 32'h00000008
`define LVM_OFF_IP 32'h00000000
`define LVM_OFF_CSEG 32'h00000004
`define LVM_OFF_SKIP 32'h0000000C
`define LVM_OFF_SP 32'h0000000C
`define LVM_OFF_SSEG 32'h00000010
`define LVM_OFF_XSEG 32'h00000014
`define LVM_OFF_DSEG 32'h00000018
`define LVM_OFF_FSEG 32'h0000001C
`define LVM_OFF_GSEG 32'h00000020
// Return read step numbers
`define LVM_RS_FLG 4'h0
`define LVM_RS_IP 4'h1
`define LVM_RS_CSEG 4'h2
`define LVM_RS_XSEG 4'h3
`define LVM_RS_GSEG 4'h6
`define LVM_RS_SP 4'h7
`define LVM_RS_SSEG 4'h8
// Reset values
`define LVM_FLAGS_RST 32'h00000002
`define LVM_ZERO32 32'h00000000
`endif

// ---- core/lvm_transition.v ----
// Legacy virtual mode entry, exit, frame build and return unit
`timescale 1ns/1ps
`include "lvm_defines.vh"
`default_nettype none
module lvm_transition (
	// Clock and reset
	input wire clk_i,
	input wire rstn_i,
	// Mode
	input wire prot_en_i,
	// Interrupt gate request
	input wire intr_req_i,
	input wire [3:0] gate_type_i,
	input wire [15:0] gate_sel_i,
	input wire [31:0] gate_off_i,
	input wire gate_conf_i,
	input wire [1:0] gate_tgt_priv_i,
	input wire [15:0] stk0_sel_i,
	input wire [31:0] stk0_ptr_i,
	// Interrupt return request
	input wire intret_req_i,
	input wire intret_op32_i,
	input wire [3:0] seg_valid_i,
	// Flag push and pop
	input wire pop_flags_req_i,
	input wire [31:0] pop_flags_data_i,
	input wire push_flags_req_i,
	// Task switch
	input wire task_req_i,
	input wire [3:0] task_type_i,
	input wire [31:0] task_flags_i,
	input wire [15:0] task_code_seg_i,
	input wire [15:0] task_stk_seg_i,
	input wire [15:0] task_data_seg_i,
	input wire [15:0] task_extra_seg_i,
	input wire [15:0] task_aux_f_seg_i,
	input wire [15:0] task_aux_g_seg_i,
	input wire [31:0] task_instr_ptr_i,
	input wire [31:0] task_stk_ptr_i,
	// Stack memory
	input wire mem_ack_i,
	input wire mem_fault_i,
	input wire [31:0] mem_rdata_i,
	// Status
	output wire busy_o,
	output wire legacy_virtual_mode_flag_o,
	output wire [31:0] flags_o,
	output wire [1:0] cur_priv_o,
	// Architectural segment and pointer state
	output wire [15:0] code_seg_o,
	output wire [15:0] stk_seg_o,
	output wire [15:0] data_seg_o,
	output wire [15:0] extra_seg_o,
	output wire [15:0] aux_f_seg_o,
	output wire [15:0] aux_g_seg_o,
	output wire [31:0] instr_ptr_o,
	output wire [31:0] stk_ptr_o,
	// Push image and task save
	output wire [31:0] push_flags_data_o,
	output wire task_save_v_o,
	output wire [31:0] task_save_flags_o,
	// Nested return and fault
	output wire nest_ret_o,
	output wire fault_o,
	output wire [15:0] fault_code_o,
	// Stack memory
	output wire mem_req_o,
	output wire mem_we_o,
	output wire [31:0] mem_addr_o,
	output wire [31:0] mem_wdata_o
);
	// One-hot states
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_TFLG = 6'h02;
	localparam [5:0] S_TSEG = 6'h04;
	localparam [5:0] S_PUSH = 6'h08;
	localparam [5:0] S_POP = 6'h10;
	localparam [5:0] S_CMT = 6'h20;

	// Return frame offset of a read step
	function [31:0] ret_off;
		input [3:0] s;
		begin
			case (s)
				4'h0: ret_off = `LVM_OFF_FLG;
				4'h1: ret_off = `LVM_OFF_IP;
				4'h2: ret_off = `LVM_OFF_CSEG;
				4'h3: ret_off = `LVM_OFF_XSEG;
				4'h4: ret_off = `LVM_OFF_DSEG;
				4'h5: ret_off = `LVM_OFF_FSEG;
				4'h6: ret_off = `LVM_OFF_GSEG;
				4'h7: ret_off = `LVM_OFF_SP;
				default: ret_off = `LVM_OFF_SSEG;
			endcase
		end
	endfunction

	// Control state
	reg [5:0] state_r;
	reg [3:0] step_r;
	reg op32_r;
	// Architectural state
	reg [31:0] flags_r;
	reg [1:0] cur_priv_r;
	reg [15:0] code_seg_r;
	reg [15:0] stk_seg_r;
	reg [15:0] data_seg_r;
	reg [15:0] extra_seg_r;
	reg [15:0] aux_f_seg_r;
	reg [15:0] aux_g_seg_r;
	reg [31:0] instr_ptr_r;
	reg [31:0] stk_ptr_r;
	// Shadow state, committed only at sequence end
	reg [31:0] base_r;
	reg [31:0] n_flags_r;
	reg [15:0] n_code_r;
	reg [15:0] n_stk_r;
	reg [15:0] n_data_r;
	reg [15:0] n_extra_r;
	reg [15:0] n_aux_f_r;
	reg [15:0] n_aux_g_r;
	reg [31:0] n_ip_r;
	reg [31:0] n_sp_r;
	// Output registers
	reg [31:0] push_img_r;
	reg task_save_v_r;
	reg [31:0] task_save_flags_r;
	reg nest_ret_r;
	reg fault_r;
	reg [15:0] fault_code_r;
	reg mem_req_r;
	reg mem_we_r;
	reg [31:0] mem_addr_r;
	reg [31:0] mem_wdata_r;

	// Decodes
	wire in_lvm = flags_r[`LVM_LVF_BIT];
	wire done = mem_req_r & mem_ack_i;
	wire gate_ok = ((gate_type_i == `LVM_TRAP_GATE32) |
		(gate_type_i == `LVM_INTR_GATE32)) & ~gate_conf_i &
		(gate_tgt_priv_i == `LVM_PRIV_KERNEL);
	wire may_set = prot_en_i & ~in_lvm & op32_r &
		(cur_priv_r == `LVM_PRIV_KERNEL);
	wire outer = mem_rdata_i[1:0] > cur_priv_r;
	wire [3:0] step_inc = step_r + 4'h1;

	// Next push word; old state still in architectural regs
	reg [3:0] pidx;
	reg [31:0] pword;
	always @* begin
		pidx = state_r[0] ? 4'h0 : step_inc;
		case (pidx)
			4'h0: pword = {16'h0000, aux_g_seg_r};
			4'h1: pword = {16'h0000, aux_f_seg_r};
			4'h2: pword = {16'h0000, data_seg_r};
			4'h3: pword = {16'h0000, extra_seg_r};
			4'h4: pword = {16'h0000, stk_seg_r};
			4'h5: pword = stk_ptr_r;
			4'h6: pword = flags_r;
			4'h7: pword = {16'h0000, code_seg_r};
			default: pword = instr_ptr_r;
		endcase
	end

	// Sequencer and architectural state
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r <= S_IDLE;
			step_r <= 4'h0;
			op32_r <= 1'b0;
			flags_r <= `LVM_FLAGS_RST;
			cur_priv_r <= `LVM_PRIV_KERNEL;
			code_seg_r <= `LVM_NULL_SEL;
			stk_seg_r <= `LVM_NULL_SEL;
			data_seg_r <= `LVM_NULL_SEL;
			extra_seg_r <= `LVM_NULL_SEL;
			aux_f_seg_r <= `LVM_NULL_SEL;
			aux_g_seg_r <= `LVM_NULL_SEL;
			instr_ptr_r <= `LVM_ZERO32;
			stk_ptr_r <= `LVM_ZERO32;
			base_r <= `LVM_ZERO32;
			n_flags_r <= `LVM_FLAGS_RST;
			n_code_r <= `LVM_NULL_SEL;
			n_stk_r <= `LVM_NULL_SEL;
			n_data_r <= `LVM_NULL_SEL;
			n_extra_r <= `LVM_NULL_SEL;
			n_aux_f_r <= `LVM_NULL_SEL;
			n_aux_g_r <= `LVM_NULL_SEL;
			n_ip_r <= `LVM_ZERO32;
			n_sp_r <= `LVM_ZERO32;
			push_img_r <= `LVM_ZERO32;
			task_save_v_r <= 1'b0;
			task_save_flags_r <= `LVM_ZERO32;
			nest_ret_r <= 1'b0;
			fault_r <= 1'b0;
			fault_code_r <= `LVM_NULL_SEL;
			mem_req_r <= 1'b0;
			mem_we_r <= 1'b0;
			mem_addr_r <= `LVM_ZERO32;
			mem_wdata_r <= `LVM_ZERO32;
		end else begin
			// Pulses default low
			task_save_v_r <= 1'b0;
			nest_ret_r <= 1'b0;
			fault_r <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (intr_req_i && in_lvm) begin
						// Exit path only from legacy mode
						if (!gate_ok) begin
							fault_r <= 1'b1;
							fault_code_r <= gate_sel_i;
						end else begin
							// Flags copy stays in flags_r until commit
							n_flags_r <= flags_r & ~((32'h1 << `LVM_LVF_BIT) |
								(32'h1 << `LVM_SSF_BIT) |
								((gate_type_i == `LVM_INTR_GATE32) ?
								(32'h1 << `LVM_IEF_BIT) : 32'h0));
							n_code_r <= gate_sel_i;
							n_ip_r <= gate_off_i;
							n_stk_r <= stk0_sel_i;
							base_r <= stk0_ptr_i;
							step_r <= 4'h0;
							mem_req_r <= 1'b1;
							mem_we_r <= 1'b1;
							mem_addr_r <= stk0_ptr_i - `LVM_WORD;
							mem_wdata_r <= pword;
							state_r <= S_PUSH;
						end
					end else if (intret_req_i) begin
						if (prot_en_i && flags_r[`LVM_NTF_BIT] && !in_lvm) begin
							// Inter-task return via link field
							nest_ret_r <= 1'b1;
						end else begin
							op32_r <= intret_op32_i;
							base_r <= stk_ptr_r;
							n_sp_r <= stk_ptr_r + `LVM_OFF_SKIP;
							n_stk_r <= stk_seg_r;
							n_data_r <= data_seg_r;
							n_extra_r <= extra_seg_r;
							n_aux_f_r <= aux_f_seg_r;
							n_aux_g_r <= aux_g_seg_r;
							step_r <= `LVM_RS_FLG;
							mem_req_r <= 1'b1;
							mem_we_r <= 1'b0;
							mem_addr_r <= stk_ptr_r + `LVM_OFF_FLG;
							state_r <= S_POP;
						end
					end else if (pop_flags_req_i) begin
						// Mode bit kept in every mode
						flags_r <= {pop_flags_data_i[31:18], in_lvm,
							pop_flags_data_i[16:0]};
					end else if (push_flags_req_i) begin
						push_img_r <= flags_r &
							~(32'h1 << `LVM_LVF_BIT);
					end else if (task_req_i && prot_en_i) begin
						// Outgoing image keeps mode bit, segs hold bases
						task_save_v_r <= 1'b1;
						task_save_flags_r <= flags_r;
						state_r <= S_TFLG;
					end
				end
				S_TFLG: begin
					// Flags first so segments load in the right style
					if ((task_type_i == `LVM_TSEG32_AVAIL) ||
						(task_type_i == `LVM_TSEG32_BUSY)) begin
						flags_r <= task_flags_i;
					end else begin
						flags_r <= {16'h0000, task_flags_i[15:0]};
					end
					state_r <= S_TSEG;
				end
				S_TSEG: begin
					// Segment images after flags
					code_seg_r <= task_code_seg_i;
					stk_seg_r <= task_stk_seg_i;
					data_seg_r <= task_data_seg_i;
					extra_seg_r <= task_extra_seg_i;
					aux_f_seg_r <= task_aux_f_seg_i;
					aux_g_seg_r <= task_aux_g_seg_i;
					instr_ptr_r <= task_instr_ptr_i;
					stk_ptr_r <= task_stk_ptr_i;
					cur_priv_r <= in_lvm ? `LVM_PRIV_USER :
						task_code_seg_i[1:0];
					state_r <= S_IDLE;
				end
				S_PUSH: begin
					if (done && mem_fault_i) begin
						// Abort, nothing committed
						mem_req_r <= 1'b0;
						fault_r <= 1'b1;
						fault_code_r <= `LVM_NULL_SEL;
						state_r <= S_IDLE;
					end else if (done && step_r == `LVM_PUSH_LAST) begin
						// Commit handler context
						mem_req_r <= 1'b0;
						flags_r <= n_flags_r;
						code_seg_r <= n_code_r;
						instr_ptr_r <= n_ip_r;
						stk_seg_r <= n_stk_r;
						stk_ptr_r <= base_r - `LVM_ENTRY_FRAME;
						data_seg_r <= `LVM_NULL_SEL;
						extra_seg_r <= `LVM_NULL_SEL;
						aux_f_seg_r <= `LVM_NULL_SEL;
						aux_g_seg_r <= `LVM_NULL_SEL;
						cur_priv_r <= `LVM_PRIV_KERNEL;
						state_r <= S_IDLE;
					end else if (done) begin
						// Next word downward
						step_r <= step_inc;
						mem_addr_r <= mem_addr_r - `LVM_WORD;
						mem_wdata_r <= pword;
					end
				end
				S_POP: begin
					if (done && mem_fault_i) begin
						mem_req_r <= 1'b0;
						fault_r <= 1'b1;
						fault_code_r <= `LVM_NULL_SEL;
						state_r <= S_IDLE;
					end else if (done) begin
						case (step_r)
							4'h0: begin
								n_flags_r <= may_set ? mem_rdata_i :
									{mem_rdata_i[31:18], in_lvm,
									mem_rdata_i[16:0]};
								step_r <= `LVM_RS_IP;
							end
							4'h1: begin
								n_ip_r <= mem_rdata_i;
								step_r <= `LVM_RS_CSEG;
							end
							4'h2: begin
								n_code_r <= mem_rdata_i[15:0];
								if (n_flags_r[`LVM_LVF_BIT]) begin
									step_r <= `LVM_RS_XSEG;
								end else if (outer) begin
									step_r <= `LVM_RS_SP;
								end else begin
									mem_req_r <= 1'b0;
									state_r <= S_CMT;
								end
							end
							4'h3: begin
								n_extra_r <= mem_rdata_i[15:0];
								step_r <= step_inc;
							end
							4'h4: begin
								n_data_r <= mem_rdata_i[15:0];
								step_r <= step_inc;
							end
							4'h5: begin
								n_aux_f_r <= mem_rdata_i[15:0];
								step_r <= step_inc;
							end
							4'h6: begin
								n_aux_g_r <= mem_rdata_i[15:0];
								step_r <= `LVM_RS_SP;
							end
							4'h7: begin
								n_sp_r <= mem_rdata_i;
								step_r <= `LVM_RS_SSEG;
							end
							default: begin
								n_stk_r <= mem_rdata_i[15:0];
								mem_req_r <= 1'b0;
								state_r <= S_CMT;
							end
						endcase
					end
				end
				S_CMT: begin
					// Restore interrupted routine
					flags_r <= n_flags_r;
					code_seg_r <= n_code_r;
					instr_ptr_r <= n_ip_r;
					stk_seg_r <= n_stk_r;
					stk_ptr_r <= n_sp_r;
					if (n_flags_r[`LVM_LVF_BIT]) begin
						// Legacy-style segment loads
						extra_seg_r <= n_extra_r;
						data_seg_r <= n_data_r;
						aux_f_seg_r <= n_aux_f_r;
						aux_g_seg_r <= n_aux_g_r;
						cur_priv_r <= `LVM_PRIV_USER;
					end else begin
						// Null selectors invalid for resumed level
						extra_seg_r <= seg_valid_i[0] ? extra_seg_r :
							`LVM_NULL_SEL;
						data_seg_r <= seg_valid_i[1] ? data_seg_r :
							`LVM_NULL_SEL;
						aux_f_seg_r <= seg_valid_i[2] ? aux_f_seg_r :
							`LVM_NULL_SEL;
						aux_g_seg_r <= seg_valid_i[3] ? aux_g_seg_r :
							`LVM_NULL_SEL;
						cur_priv_r <= prot_en_i ? n_code_r[1:0] :
							`LVM_PRIV_KERNEL;
					end
					state_r <= S_IDLE;
				end
				default: begin
					mem_req_r <= 1'b0;
					state_r <= S_IDLE;
				end
			endcase
			// Next read address from frame base
			if (state_r == S_POP && done && !mem_fault_i) begin
				mem_addr_r <= base_r + ret_off(
					(step_r == 4'h2 && !n_flags_r[`LVM_LVF_BIT]) ?
					`LVM_RS_SP : (step_r == `LVM_RS_GSEG) ?
					`LVM_RS_SP : step_inc);
			end
		end
	end

	// Outputs straight from flops, except busy_o, which is the inverted idle state bit
	assign busy_o = ~state_r[0];
	assign legacy_virtual_mode_flag_o = flags_r[`LVM_LVF_BIT];
	assign flags_o = flags_r;
	assign cur_priv_o = cur_priv_r;
	assign code_seg_o = code_seg_r;
	assign stk_seg_o = stk_seg_r;
	assign data_seg_o = data_seg_r;
	assign extra_seg_o = extra_seg_r;
	assign aux_f_seg_o = aux_f_seg_r;
	assign aux_g_seg_o = aux_g_seg_r;
	assign instr_ptr_o = instr_ptr_r;
	assign stk_ptr_o = stk_ptr_r;
	assign push_flags_data_o = push_img_r;
	assign task_save_v_o = task_save_v_r;
	assign task_save_flags_o = task_save_flags_r;
	assign nest_ret_o = nest_ret_r;
	assign fault_o = fault_r;
	assign fault_code_o = fault_code_r;
	assign mem_req_o = mem_req_r;
	assign mem_we_o = mem_we_r;
	assign mem_addr_o = mem_addr_r;
	assign mem_wdata_o = mem_wdata_r;
endmodule // lvm_transition
`default_nettype wire

// ---- tb/lvm_transition_chk.sv ----
// Checker of the legacy virtual mode transition unit
`timescale 1ns/1ps
`default_nettype none
`include "lvm_defines.vh"
module lvm_chk (
	// Clock, reset and requests
	input wire logic clk_i, rstn_i, prot_en_i, intr_req_i, gate_conf_i, intret_req_i,
	input wire logic pop_flags_req_i, mem_ack_i, mem_fault_i,
	input wire logic [3:0] gate_type_i,
	input wire logic [1:0] gate_tgt_priv_i,
	input wire logic [15:0] gate_sel_i,
	input wire logic [31:0] stk0_ptr_i,
	// Observed state
	input wire logic busy_o, legacy_virtual_mode_flag_o, nest_ret_o, fault_o, mem_req_o, mem_we_o,
	input wire logic [1:0] cur_priv_o,
	input wire logic [15:0] data_seg_o, fault_code_o,
	input wire logic [31:0] flags_o, stk_ptr_o, push_flags_data_o, mem_addr_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// Gate unfit for leaving legacy mode
	wire logic bad_w = !(gate_type_i == `LVM_TRAP_GATE32 || gate_type_i == `LVM_INTR_GATE32)
		|| gate_conf_i || gate_tgt_priv_i != `LVM_PRIV_KERNEL;
	// Requests the idle unit accepts, by priority
	wire logic intr_w = !busy_o && intr_req_i && legacy_virtual_mode_flag_o;
	wire logic ret_w = !busy_o && !intr_w && intret_req_i;
	wire logic pop_w = !busy_o && !intr_w && !intret_req_i && pop_flags_req_i;
	wire logic nest_w = prot_en_i && flags_o[`LVM_NTF_BIT] && !legacy_virtual_mode_flag_o;
	// Interrupt through a fit gate
	sequence s_good_intr;
		intr_w && !bad_w;
	endsequence
	// Mode flag drops right after the last frame write
	sequence s_frame_done;
		$fell(legacy_virtual_mode_flag_o) && $past(mem_req_o);
	endsequence
	property p_push_zero;
		push_flags_data_o[`LVM_LVF_BIT] == 1'b0;
	endproperty
	a_push_zero: assert property (p_push_zero) else $error("mode bit in push image");
	property p_pop_keep;
		pop_w |=> $stable(legacy_virtual_mode_flag_o);
	endproperty
	a_pop_keep: assert property (p_pop_keep) else $error("pop changed mode flag");
	property p_bad_gate;
		intr_w && bad_w |=> fault_o && fault_code_o == $past(gate_sel_i) && !mem_req_o;
	endproperty
	a_bad_gate: assert property (p_bad_gate) else $error("bad gate not refused");
	property p_entry_start;
		s_good_intr |=> mem_req_o && mem_we_o && mem_addr_o == $past(stk0_ptr_i) - `LVM_WORD;
	endproperty
	a_entry_start: assert property (p_entry_start) else $error("entry frame start wrong");
	property p_entry_end;
		s_frame_done |-> !busy_o && !flags_o[`LVM_SSF_BIT] && cur_priv_o == `LVM_PRIV_KERNEL
			&& data_seg_o == `LVM_NULL_SEL;
	endproperty
	a_entry_end: assert property (p_entry_end) else $error("entry end state wrong");
	property p_ret_start;
		ret_w && !nest_w |=> mem_req_o && !mem_we_o && mem_addr_o == $past(stk_ptr_o) + `LVM_OFF_FLG;
	endproperty
	a_ret_start: assert property (p_ret_start) else $error("return read start wrong");
	property p_nest;
		ret_w && nest_w |=> nest_ret_o && !mem_req_o;
	endproperty
	a_nest: assert property (p_nest) else $error("nested return not flagged");
	property p_rise;
		$rose(legacy_virtual_mode_flag_o) |-> $past(busy_o) && $past(prot_en_i);
	endproperty
	a_rise: assert property (p_rise) else $error("mode flag set outside a sequence");
	property p_mem_fault;
		mem_req_o && mem_ack_i && mem_fault_i |=> fault_o && !mem_req_o
			&& fault_code_o == `LVM_NULL_SEL && $stable(legacy_virtual_mode_flag_o);
	endproperty
	a_mem_fault: assert property (p_mem_fault) else $error("frame fault changed state");
endmodule // lvm_chk
bind lvm_transition lvm_chk i_lvm_chk (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench of the legacy virtual mode transition unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
	// Design inputs
	logic clk_i, rstn_i, prot_en_i, intr_req_i, gate_conf_i, intret_req_i, intret_op32_i;
	logic pop_flags_req_i, push_flags_req_i, task_req_i, mem_ack_i, mem_fault_i;
	logic [1:0] gate_tgt_priv_i;
	logic [3:0] gate_type_i, seg_valid_i, task_type_i;
	logic [15:0] gate_sel_i, stk0_sel_i, task_code_seg_i, task_stk_seg_i, task_data_seg_i;
	logic [15:0] task_extra_seg_i, task_aux_f_seg_i, task_aux_g_seg_i;
	logic [31:0] gate_off_i, stk0_ptr_i, pop_flags_data_i, task_flags_i, task_instr_ptr_i;
	logic [31:0] task_stk_ptr_i, mem_rdata_i;
	// Design outputs
	wire busy_o, legacy_virtual_mode_flag_o, task_save_v_o, nest_ret_o, fault_o, mem_req_o, mem_we_o;
	wire [1:0] cur_priv_o;
	wire [15:0] code_seg_o, stk_seg_o, data_seg_o, extra_seg_o, aux_f_seg_o, aux_g_seg_o, fault_code_o;
	wire [31:0] flags_o, instr_ptr_o, stk_ptr_o, push_flags_data_o, task_save_flags_o;
	wire [31:0] mem_addr_o, mem_wdata_o;
	// Bench state
	typedef struct packed {logic psh; logic [31:0] d, e;} lvm_row_t;
	lvm_row_t rows [4] = '{'{1'b0, 32'h00020202, 32'h00000202}, '{1'b1, 32'h0, 32'h00000202},
		'{1'b0, 32'h00004102, 32'h00004102}, '{1'b1, 32'h0, 32'h00004102}};
	logic [6:0] bad [3] = '{7'h30, 7'h7C, 7'h71}; // Gate type, conforming, target level
	int n_errors, comparisons;
	logic slow, fault_arm; // Memory stalls, fault injection
	logic [31:0] mem [0:1023]; // Stack memory, word indexed
	logic [31:0] old [0:8]; // Expected entry frame
	lvm_transition i_lvm_transition (.*);
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Stack memory answers at the falling edge; stalls every other cycle when slow
	always @(negedge clk_i) begin
		mem_ack_i <= mem_req_o && !(slow && mem_ack_i);
		mem_fault_i <= mem_req_o && fault_arm && mem_addr_o == 32'h000003F0;
		// Idle bus shows the inverse of the addressed word
		mem_rdata_i <= mem_req_o ? mem[mem_addr_o[11:2]] : ~mem[mem_addr_o[11:2]];
	end
	// Writes land at the accepting edge
	always @(posedge clk_i) begin
		if (mem_req_o && mem_ack_i && mem_we_o) mem[mem_addr_o[11:2]] <= mem_wdata_o;
	end
	// One-cycle request pulse {task, push, pop, return, interrupt}
	task automatic req(input logic [4:0] r);
		{task_req_i, push_flags_req_i, pop_flags_req_i, intret_req_i, intr_req_i} = r;
		@(negedge clk_i);
		{task_req_i, push_flags_req_i, pop_flags_req_i, intret_req_i, intr_req_i} = 5'h00;
	endtask
	// Bounded wait for idle
	task automatic wait_idle;
		int i;
		for (i = 0; i < 200 && busy_o !== 1'b0; i++) @(negedge clk_i);
		if (i == 200) begin
			n_errors++;
			$display("ERROR busy_o expected 0 seen %b", busy_o);
			test_done;
		end
		@(negedge clk_i);
	endtask
	// Counts and verdict
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		{n_errors, comparisons, slow, fault_arm, intret_op32_i, task_type_i, task_flags_i} = '0;
		{rstn_i, prot_en_i, seg_valid_i, stk0_sel_i, stk0_ptr_i} = {2'h1, 4'hF, 48'h001000000400};
		{intr_req_i, intret_req_i, pop_flags_req_i, push_flags_req_i, task_req_i} = 5'h00;
		pop_flags_data_i = '0;
		{gate_type_i, gate_sel_i, gate_off_i, gate_conf_i, gate_tgt_priv_i} = '0;
		{task_code_seg_i, task_stk_seg_i, task_data_seg_i, task_extra_seg_i} = '0;
		{task_aux_f_seg_i, task_aux_g_seg_i, task_instr_ptr_i, task_stk_ptr_i} = '0;
		foreach (mem[i]) mem[i] = 32'h0;
		mem[2] = 32'h00020002;
		mem[5] = 32'h00020002;
		repeat (4) @(negedge clk_i);
		rstn_i = 1'b1;
		`CHK("reset state", {32'h00000002, 3'h0}, {flags_o, cur_priv_o, busy_o})
		foreach (rows[i]) begin
			pop_flags_data_i = rows[i].d;
			req(rows[i].psh ? 5'h08 : 5'h04);
			wait_idle;
			`CHK("flags image", rows[i].e, rows[i].psh ? push_flags_data_o : flags_o)
		end
		req(5'h02);
		`CHK("nested return", 2'h2, {nest_ret_o, mem_req_o})
		wait_idle;
		pop_flags_data_i = 32'h00000002;
		req(5'h04);
		wait_idle;
		$display("Test flags and nested return done");
		for (int k = 0; k < 2; k++) begin
			{intret_op32_i, prot_en_i} = {k[0], !k[0]};
			req(5'h02);
			wait_idle;
			`CHK("mode flag", 1'b0, legacy_virtual_mode_flag_o)
		end
		{intret_op32_i, prot_en_i} = 2'h3;
		$display("Test returns without entry done");
		for (int k = 0; k < 3; k++) begin
			task_type_i = k == 1 ? 4'h3 : (k == 0 ? 4'h9 : 4'hB);
			task_flags_i = 32'h00020302;
			{task_code_seg_i, task_stk_seg_i, task_data_seg_i} = {3{16'h1003 + 16'(k * 16'h1110)}};
			{task_extra_seg_i, task_aux_f_seg_i, task_aux_g_seg_i} = {3{task_data_seg_i}};
			{task_instr_ptr_i, task_stk_ptr_i} = {2{32'h00000FF0 - 32'(k)}};
			req(5'h10);
			`CHK("saved mode bit", {1'b1, k == 1}, {task_save_v_o, task_save_flags_o[17]})
			wait_idle;
			`CHK("mode flag", k != 1, legacy_virtual_mode_flag_o)
			if (k == 1) begin
				// Protected return nulls selectors marked invalid
				seg_valid_i = 4'h5;
				req(5'h02);
				wait_idle;
				`CHK("null invalid", 64'h2113_0000_2113_0000, {extra_seg_o, data_seg_o, aux_f_seg_o, aux_g_seg_o})
				seg_valid_i = 4'hF;
			end
		end
		`CHK("task load", {32'h00020302, 16'h3223, 2'h3}, {flags_o, data_seg_o, cur_priv_o})
		req(5'h08);
		wait_idle;
		`CHK("push image", 32'h00000302, push_flags_data_o)
		pop_flags_data_i = 32'h00000302;
		req(5'h04);
		wait_idle;
		`CHK("mode flag", 1'b1, legacy_virtual_mode_flag_o)
		for (int k = 0; k < 3; k++) begin
			{gate_type_i, gate_conf_i, gate_tgt_priv_i} = bad[k];
			gate_sel_i = 16'h0A08 + 16'(k);
			req(5'h01);
			`CHK("gate fault", {1'b1, 16'h0A08 + 16'(k)}, {fault_o, fault_code_o})
			wait_idle;
			`CHK("mode flag", 1'b1, legacy_virtual_mode_flag_o)
		end
		$display("Test task switch and gates done");
		for (int k = 0; k < 2; k++) begin
			{slow, gate_type_i, gate_conf_i, gate_tgt_priv_i} = {k[0], k[0] ? 4'hE : 4'hF, 3'h0};
			{gate_sel_i, gate_off_i} = {16'h0008, 32'h00008000 + 32'(k)};
			old = '{{16'h0, aux_g_seg_o}, {16'h0, aux_f_seg_o}, {16'h0, data_seg_o},
				{16'h0, extra_seg_o}, {16'h0, stk_seg_o}, stk_ptr_o, flags_o,
				{16'h0, code_seg_o}, instr_ptr_o};
			req(5'h01);
			wait_idle;
			for (int j = 0; j < 9; j++) `CHK("frame word", old[j], mem[255 - j])
			`CHK("entry flags", old[6] & ~(k ? 32'h00020100 : 32'h00020300), flags_o)
			`CHK("null segs", 64'h0, {data_seg_o, extra_seg_o, aux_f_seg_o, aux_g_seg_o})
			`CHK("handler", {16'h0008, gate_off_i, 2'h0}, {code_seg_o, instr_ptr_o, cur_priv_o})
			`CHK("new stack", {16'h0010, 32'h000003DC}, {stk_seg_o, stk_ptr_o})
			req(5'h02);
			wait_idle;
			`CHK("ret flags", old[6], flags_o)
			`CHK("ret segs", {old[0][15:0], old[1][15:0], old[2][15:0], old[3][15:0]},
				{aux_g_seg_o, aux_f_seg_o, data_seg_o, extra_seg_o})
			`CHK("ret ptrs", {old[4][15:0], old[5], old[7][15:0], old[8]},
				{stk_seg_o, stk_ptr_o, code_seg_o, instr_ptr_o})
		end
		$display("Test entry and return done");
		fault_arm = 1'b1;
		req(5'h01);
		for (int i = 0; i < 20 && fault_o !== 1'b1; i++) @(negedge clk_i);
		`CHK("frame fault", {17'h10000, 17'h13223},
			{fault_o, fault_code_o, legacy_virtual_mode_flag_o, data_seg_o})
		fault_arm = 1'b0;
		wait_idle;
		$display("Test frame fault done");
		// Reset again in mid-run
		rstn_i = 1'b0;
		@(negedge clk_i);
		rstn_i = 1'b1;
		`CHK("mid-run reset", {32'h00000002, 4'h0, 16'h0}, {flags_o, cur_priv_o, busy_o, mem_req_o, data_seg_o})
		$display("Test mid-run reset done");
		test_done;
	end
endmodule // tb_top
`default_nettype wire
